//--- rtl/wdtu_regs.vh
// Register indices, field positions, reset values and timing counts
`ifndef WDTU_REGS_VH
`define WDTU_REGS_VH

// Register indices; the byte address is four times the index
`define WDTU_IDX_CFG 10'h000
`define WDTU_IDX_STATE 10'h001
`define WDTU_IDX_KEY 10'h002

// Control register fields
`define WDTU_WIN_MSB 7
`define WDTU_WIN_LSB 4
`define WDTU_PER_MSB 3
`define WDTU_PER_LSB 0

// Status register fields
`define WDTU_LOCK_BIT 7
`define WDTU_BUSY_BIT 0

// Reset values
`define WDTU_CFG_RST 8'h00
`define WDTU_STATE_RST 8'h00
`define WDTU_LOCK_RST 1'b0

// Length codes: 0x1 is 8 cycles, doubling up to 0xB
`define WDTU_BASE_LEN 14'h0008
`define WDTU_MAX_CODE 4'hB

// Slow clock edges a crossing waits for before it takes effect
`define WDTU_SYNC_TICKS 2'h2

// Bus transfers that stay unlocked after the key is written
`define WDTU_UNLOCK_SPAN 3'h4

// Watchdog states
`define WDTU_ST_OFF 3'h0
`define WDTU_ST_NORMAL 3'h1
`define WDTU_ST_ARM 3'h2
`define WDTU_ST_CLOSED 3'h3
`define WDTU_ST_OPEN 3'h4

`endif

//--- rtl/wdtu_sync.v
// Two flip-flop synchroniser for levels from outside the pclk domain
module wdtu_sync
#(
    parameter WIDTH = 1
)
(
    input wire pclk,
    input wire presetn,
    input wire [WIDTH-1:0] async_in,
    output wire [WIDTH-1:0] sync_out
);

    reg [WIDTH-1:0] meta_q;
    reg [WIDTH-1:0] sync_q;

    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            meta_q <= {WIDTH{1'b0}};
            sync_q <= {WIDTH{1'b0}};
        end
        else
        begin
            meta_q <= async_in;
            sync_q <= meta_q;
        end
    end

    assign sync_out = sync_q;

endmodule

//--- rtl/wdtu_top.v
// Windowed watchdog unit with APB registers and a slow counting clock
//
// Our own choice: the APB register port.
`include "wdtu_regs.vh"

module wdtu_top
#(
    parameter [7:0] UNLOCK_KEY = 8'h5A
)
(
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output wire [31:0] prdata,
    output wire pready,
    output wire pslverr,
    input wire slow_counter_clock,
    input wire watchdog_clear_request,
    input wire debug_halt,
    input wire boot_done,
    input wire [7:0] boot_watchdog_fuse,
    output wire system_reset
);

    reg [31:0] prdata_q;
    reg pready_q;
    reg pslverr_q;
    reg [7:0] cfg_q;
    reg [7:0] cfg_act_q;
    reg lock_q;
    reg busy_q;
    reg [1:0] cfg_ticks_q;
    reg [2:0] unlock_cnt_q;
    reg boot_seen_q;
    reg osc_prev_q;
    reg clr_pend_q;
    reg [1:0] clr_ticks_q;
    reg [2:0] st_q;
    reg [13:0] cnt_q;
    reg halted_q;
    reg sysrst_q;

    wire osc_s;
    wire tick;
    wire access;
    wire done;
    wire hit_cfg;
    wire hit_state;
    wire hit_key;
    wire hit;
    wire unlock_open;
    wire wr_cfg_ok;
    wire wr_state_ok;
    wire boot_load;
    wire cfg_now;
    wire clr_now;
    wire [13:0] len;

    // Length of one period for a 4-bit code; reserved codes act as 0xB
    function [13:0] wdtu_len;
        input [3:0] code;
        reg [3:0] c;
        begin
            c = (code > `WDTU_MAX_CODE) ? `WDTU_MAX_CODE : code;
            wdtu_len = `WDTU_BASE_LEN << (c - 4'h1);
        end
    endfunction

    // Starting state for a configuration
    function [2:0] wdtu_mode;
        input [7:0] c;
        begin
            if (c[`WDTU_PER_MSB:`WDTU_PER_LSB] == 4'h0)
                wdtu_mode = `WDTU_ST_OFF;
            else if (c[`WDTU_WIN_MSB:`WDTU_WIN_LSB] != 4'h0)
                wdtu_mode = `WDTU_ST_ARM;
            else
                wdtu_mode = `WDTU_ST_NORMAL;
        end
    endfunction

    // The oscillator pin is sampled, then its rising edge becomes a tick
    wdtu_sync #(
        .WIDTH(1)
    ) u_osc_sync (
        .pclk(pclk),
        .presetn(presetn),
        .async_in(slow_counter_clock),
        .sync_out(osc_s)
    );

    assign tick = osc_s & ~osc_prev_q;

    assign access = psel & penable;
    assign done = access & pready_q;
    assign hit_cfg = (paddr[11:2] == `WDTU_IDX_CFG);
    assign hit_state = (paddr[11:2] == `WDTU_IDX_STATE);
    assign hit_key = (paddr[11:2] == `WDTU_IDX_KEY);
    assign hit = (paddr[1:0] == 2'h0) & (hit_cfg | hit_state | hit_key);
    assign unlock_open = (unlock_cnt_q != 3'h0);
    // Control register writes while busy are dropped rather than corrupting the crossing
    assign wr_cfg_ok = done & pwrite & hit & hit_cfg & unlock_open
                       & ~lock_q & ~busy_q;
    assign wr_state_ok = done & pwrite & hit & hit_state
                         & unlock_open;
    assign boot_load = boot_done & ~boot_seen_q;
    assign cfg_now = tick & busy_q
                     & (cfg_ticks_q == `WDTU_SYNC_TICKS - 2'h1);
    assign clr_now = tick & clr_pend_q
                     & (clr_ticks_q == `WDTU_SYNC_TICKS - 2'h1);
    assign len = (st_q == `WDTU_ST_CLOSED) ?
                 wdtu_len(cfg_act_q[`WDTU_WIN_MSB:`WDTU_WIN_LSB]) :
                 wdtu_len(cfg_act_q[`WDTU_PER_MSB:`WDTU_PER_LSB]);

    // APB slave: one wait state, read data and error from flops
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready_q <= 1'b0;
            prdata_q <= 32'h00000000;
            pslverr_q <= 1'b0;
        end
        else
        begin
            pready_q <= access & ~pready_q;
            if (access & ~pready_q)
            begin
                pslverr_q <= ~hit;
                if (!pwrite & hit & hit_cfg)
                    prdata_q <= {24'h000000, cfg_q};
                else if (!pwrite & hit & hit_state)
                    prdata_q <= {24'h000000, lock_q, 6'h00, busy_q};
                else
                    prdata_q <= 32'h00000000;
            end
            else
            begin
                pslverr_q <= 1'b0;
            end
        end
    end

    // Unlock window, control register and lock bit
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            unlock_cnt_q <= 3'h0;
            cfg_q <= `WDTU_CFG_RST;
            lock_q <= `WDTU_LOCK_RST;
            boot_seen_q <= 1'b0;
        end
        else
        begin
            if (done & pwrite & hit & hit_key
                & (pwdata[7:0] == UNLOCK_KEY))
                unlock_cnt_q <= `WDTU_UNLOCK_SPAN;
            else if (done & unlock_open)
                unlock_cnt_q <= unlock_cnt_q - 3'h1;
            if (boot_load)
            begin
                boot_seen_q <= 1'b1;
                cfg_q <= boot_watchdog_fuse;
                if (boot_watchdog_fuse[`WDTU_PER_MSB:`WDTU_PER_LSB] != 4'h0)
                    lock_q <= 1'b1;
            end
            else
            begin
                if (wr_cfg_ok)
                    cfg_q <= pwdata[7:0];
                if (wr_state_ok & pwdata[`WDTU_LOCK_BIT])
                    lock_q <= 1'b1;
                else if (wr_state_ok & debug_halt)
                    lock_q <= 1'b0;
            end
        end
    end

    // Slow-clock side: crossings, window state machine and counter
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            osc_prev_q <= 1'b0;
            busy_q <= 1'b0;
            cfg_ticks_q <= 2'h0;
            cfg_act_q <= `WDTU_CFG_RST;
            clr_pend_q <= 1'b0;
            clr_ticks_q <= 2'h0;
            st_q <= `WDTU_ST_OFF;
            cnt_q <= 14'h0000;
            halted_q <= 1'b0;
            sysrst_q <= 1'b0;
        end
        else
        begin
            osc_prev_q <= osc_s;
            sysrst_q <= 1'b0;
            if (wr_cfg_ok)
            begin
                busy_q <= 1'b1;
                cfg_ticks_q <= 2'h0;
            end
            else if (tick & busy_q)
            begin
                if (cfg_now)
                    busy_q <= 1'b0;
                else
                    cfg_ticks_q <= cfg_ticks_q + 2'h1;
            end
            if (watchdog_clear_request & ~clr_pend_q)
            begin
                clr_pend_q <= 1'b1;
                clr_ticks_q <= 2'h0;
            end
            else if (tick & clr_pend_q)
            begin
                if (clr_now)
                    clr_pend_q <= 1'b0;
                else
                    clr_ticks_q <= clr_ticks_q + 2'h1;
            end
            // No sleep input gates this logic; only the oscillator and debug_halt do
            if (boot_load)
            begin
                cfg_act_q <= boot_watchdog_fuse;
                cnt_q <= 14'h0000;
                st_q <= wdtu_mode(boot_watchdog_fuse);
            end
            else if (cfg_now)
            begin
                cfg_act_q <= cfg_q;
                cnt_q <= 14'h0000;
                st_q <= wdtu_mode(cfg_q);
            end
            else if (debug_halt)
            begin
                halted_q <= 1'b1;
                cnt_q <= 14'h0000;
            end
            else if (halted_q)
            begin
                // A plain timeout first, the closed period after a clear
                halted_q <= 1'b0;
                cnt_q <= 14'h0000;
                st_q <= wdtu_mode(cfg_act_q);
            end
            else if (st_q != `WDTU_ST_OFF)
            begin
                if (clr_now)
                begin
                    cnt_q <= 14'h0000;
                    case (st_q)
                        `WDTU_ST_ARM: st_q <= `WDTU_ST_CLOSED;
                        `WDTU_ST_OPEN: st_q <= `WDTU_ST_CLOSED;
                        `WDTU_ST_CLOSED:
                        begin
                            sysrst_q <= 1'b1;
                            st_q <= `WDTU_ST_ARM;
                        end
                        default: st_q <= st_q;
                    endcase
                end
                else if (tick)
                begin
                    if (cnt_q == len - 14'h0001)
                    begin
                        cnt_q <= 14'h0000;
                        if (st_q == `WDTU_ST_CLOSED)
                        begin
                            st_q <= `WDTU_ST_OPEN;
                        end
                        else
                        begin
                            sysrst_q <= 1'b1;
                            st_q <= wdtu_mode(cfg_act_q);
                        end
                    end
                    else
                    begin
                        cnt_q <= cnt_q + 14'h0001;
                    end
                end
            end
        end
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign system_reset = sysrst_q;

endmodule

//--- dv/wdtu_asserts.sv
// Port-level checks for the watchdog unit
module wdtu_asserts (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] prdata,
    input wire pready,
    input wire pslverr,
    input wire debug_halt,
    input wire system_reset
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire bad = paddr[11:2] > 10'h002 || paddr[1:0] != 2'h0;
    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_wait;
        psel && penable && !pready;
    endsequence
    a_ready_wait: assert property (s_setup |=> s_wait ##1 pready)
        else $error("no answer after one wait state");
    a_ready_single: assert property (pready |=> !pready)
        else $error("ready held too long");
    a_idle_ready: assert property (!psel |=> !pready)
        else $error("ready without a request");
    a_rdata_upper: assert property (pready |-> prdata[31:8] == 24'h000000)
        else $error("read data upper bits set");
    a_bad_addr: assert property (pready && bad |-> pslverr)
        else $error("bad address not refused");
    a_good_addr: assert property (pready && !bad |-> !pslverr)
        else $error("good address refused");
    a_key_zero: assert property (pready && !pwrite && paddr == 12'h008
        |-> prdata == 32'h00000000)
        else $error("key register reads nonzero");
    a_pulse_single: assert property (system_reset |=> !system_reset)
        else $error("reset pulse too long");
    a_halt_quiet: assert property (debug_halt [*4] |-> !system_reset)
        else $error("reset during debug halt");
endmodule

bind wdtu_top wdtu_asserts wdtu_asserts_inst (.pclk, .presetn, .psel,
    .penable, .pwrite, .paddr, .prdata, .pready, .pslverr, .debug_halt,
    .system_reset);

//--- dv/windowed_watchdog_timer_tb_top.sv
// Self-checking bench for the windowed watchdog unit
module windowed_watchdog_timer_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [7:0] KEY = 8'h5A;
    localparam logic [11:0] A_CFG = 12'h000;
    localparam logic [11:0] A_ST = 12'h004;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h00000000;
    logic slow_clk = 0, clr = 0, halt = 0, boot = 0;
    logic [7:0] fuse = 8'h0B;
    logic [31:0] prdata;
    logic pready, pslverr, sys_rst, e;
    logic [7:0] q;
    int err_total = 0;
    int n_tests = 0;
    wdtu_top #(.UNLOCK_KEY(KEY)) wdtu_top_inst (.pclk(pclk),
        .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .slow_counter_clock(slow_clk),
        .watchdog_clear_request(clr), .debug_halt(halt), .boot_done(boot),
        .boot_watchdog_fuse(fuse), .system_reset(sys_rst));
    initial forever #25 pclk = ~pclk;
    // Slow clock sped up so long periods stay short; phase unrelated
    initial forever #263 slow_clk = ~slow_clk;
    task automatic chk(string nm, logic [7:0] ex, logic [7:0] got);
        n_tests++;
        if (got !== ex)
        begin
            err_total++;
            $display("MISMATCH %s expected %h seen %h", nm, ex, got);
        end
    endtask
    task automatic apb(logic wr, logic [11:0] a, logic [7:0] d);
        int n;
        psel <= 1'h1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= {24'h000000, d};
        @(posedge pclk);
        penable <= 1'h1;
        n = 0;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'h1 && n < 20);
        q = prdata[7:0];
        e = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
        if (n == 20)
            err_total++;
        @(posedge pclk);
    endtask
    task automatic rchk(string nm, logic [11:0] a, logic [7:0] ex);
        apb(1'h0, a, 8'h00);
        chk(nm, ex, q);
    endtask
    task automatic pwr(logic [11:0] a, logic [7:0] d);
        apb(1'h1, 12'h008, KEY);
        apb(1'h1, a, d);
    endtask
    task automatic idle_busy();
        int n;
        n = 0;
        do
        begin
            apb(1'h0, A_ST, 8'h00);
            n++;
        end
        while (q[0] !== 1'h0 && n < 40);
        chk("busy", 8'h00, {7'h00, q[0]});
    endtask
    task automatic wclr();
        clr <= 1'h1;
        @(posedge pclk);
        clr <= 1'h0;
    endtask
    task automatic quiet(int c);
        int n;
        n = 0;
        repeat (c)
        begin
            @(posedge pclk);
            if (sys_rst === 1'h1)
                n++;
        end
        chk("reset count", 8'h00, n[7:0]);
    endtask
    task automatic to_rst(int lo, int hi);
        int n;
        n = 0;
        while (sys_rst !== 1'h1 && n < hi)
        begin
            @(posedge pclk);
            n++;
        end
        n_tests++;
        if (n < lo || n >= hi)
        begin
            err_total++;
            $display("MISMATCH reset delay expected %0d..%0d seen %0d",
                     lo, hi, n);
        end
        @(posedge pclk);
    endtask
    task automatic t_regs();
        rchk("cfg", A_CFG, 8'h00);
        rchk("state", A_ST, 8'h00);
        rchk("key", 12'h008, 8'h00);
        apb(1'h0, 12'h00C, 8'h00);
        chk("unmapped", 8'h01, {7'h00, e});
        apb(1'h0, 12'h001, 8'h00);
        chk("misaligned", 8'h01, {7'h00, e});
        $display("t_regs done");
    endtask
    task automatic t_boot();
        boot <= 1'h1;
        @(posedge pclk);
        rchk("fuse cfg", A_CFG, 8'h0B);
        rchk("fuse lock", A_ST, 8'h80);
        pwr(A_CFG, 8'h00);
        rchk("locked cfg", A_CFG, 8'h0B);
        pwr(A_ST, 8'h00);
        rchk("lock held", A_ST, 8'h80);
        halt <= 1'h1;
        pwr(A_ST, 8'h00);
        rchk("lock debug", A_ST, 8'h00);
        halt <= 1'h0;
        // Use up what is left of the last unlock span first
        repeat (4) apb(1'h0, A_CFG, 8'h00);
        apb(1'h1, A_CFG, 8'h01);
        rchk("no key cfg", A_CFG, 8'h0B);
        apb(1'h1, A_ST, 8'h80);
        rchk("no key lock", A_ST, 8'h00);
        pwr(A_CFG, 8'h01);
        rchk("busy set", A_ST, 8'h01);
        idle_busy();
        rchk("new cfg", A_CFG, 8'h01);
        $display("t_boot done");
    endtask
    task automatic t_normal();
        repeat (8)
        begin
            wclr();
            quiet(40);
        end
        to_rst(50, 75);
        $display("t_normal done");
    endtask
    task automatic t_span();
        // The fifth transfer after the key is already outside the span
        apb(1'h1, 12'h008, KEY);
        repeat (4) apb(1'h0, A_CFG, 8'h00);
        apb(1'h1, A_CFG, 8'h02);
        rchk("late write", A_CFG, 8'h01);
        apb(1'h1, 12'h008, KEY);
        repeat (3) apb(1'h0, A_CFG, 8'h00);
        apb(1'h1, A_CFG, 8'h11);
        idle_busy();
        rchk("span cfg", A_CFG, 8'h11);
        $display("t_span done");
    endtask
    task automatic t_window();
        wclr();
        quiet(3);
        wclr();
        quiet(60);
        wclr();
        to_rst(8, 30);
        wclr();
        quiet(130);
        wclr();
        quiet(60);
        to_rst(110, 145);
        $display("t_window done");
    endtask
    task automatic t_debug();
        halt <= 1'h1;
        quiet(300);
        halt <= 1'h0;
        to_rst(70, 95);
        $display("t_debug done");
    endtask
    task automatic wrap_up();
        $display("tests %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    initial
    begin
        repeat (10) @(posedge pclk);
        presetn <= 1'h1;
        @(posedge pclk);
        t_regs();
        t_boot();
        t_normal();
        t_span();
        t_window();
        t_debug();
        wrap_up();
    end
    initial
    begin
        repeat (20000) @(posedge pclk);
        err_total++;
        wrap_up();
    end
endmodule
